// ---- fpa_pkg.sv ----
package fpa_pkg;

  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned MS_TICK_CYC  = CLK_HZ / MS_PER_S;
  localparam int unsigned FIELD_W      = 18;

  // Times in milliseconds
  localparam int unsigned REFRESH_MS   = 16;
  localparam int unsigned PULSE_MS     = 50;
  localparam int unsigned BLIP_PER_MS  = 2000;
  localparam int unsigned DEBOUNCE_MS  = 20;
  localparam int unsigned CHIRP_MS     = 100;
  localparam int unsigned BEEP_MS      = 100;
  localparam int unsigned SECOND_MS    = 1000;
  localparam int unsigned HOLD_DIAG_MS = 1500;
  localparam int unsigned HOLD_ADDR_MS = 3000;
  localparam int unsigned HOLD_CFG_MS  = 5000;
  localparam int unsigned DIAG_ID_MS   = 500;
  localparam int unsigned DIAG_DAT_MS  = 2500;
  localparam int unsigned TIMEBASE_MS  = 6000;  // Common multiple of all periods
  // Blink periods in milliseconds, one per flash rate
  localparam int unsigned PER_1HZ      = MS_PER_S / 1;
  localparam int unsigned PER_2HZ      = MS_PER_S / 2;
  localparam int unsigned PER_4HZ      = MS_PER_S / 4;
  localparam int unsigned PER_5HZ      = MS_PER_S / 5;

  localparam logic [2:0] CHIRPS_DIAG   = 3'h1;
  localparam logic [2:0] CHIRPS_ADDR   = 3'h2;
  localparam logic [2:0] CHIRPS_CFG    = 3'h5;
  localparam logic [3:0] DIAG_SCREENS  = 4'h8;

  // Register byte offsets
  localparam logic [7:0] OFS_MON       = 8'h00;
  localparam logic [7:0] OFS_CFG_LIVE  = 8'h04;
  localparam logic [7:0] OFS_CFG_ACT   = 8'h08;
  localparam logic [7:0] OFS_FIELD     = 8'h0c;
  localparam logic [7:0] OFS_INVOLVED  = 8'h10;
  localparam logic [7:0] OFS_SERIAL    = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;

  // Reset values
  localparam logic [31:0] RST_MON      = 32'h0000_0001;
  localparam logic [31:0] RST_CFG      = 32'h0000_0000;

  // Monitor state word written by firmware
  typedef struct packed {
    logic [7:0] spare;
    logic       buzz_dis;       // Silences pending-change beeps only
    logic       critical;
    logic       sf2;
    logic       sf1;
    logic       coil_low;
    logic       permit_low;
    logic       card16;
    logic       wdt_sw_dis;
    logic       fw_pending;
    logic       fw_rx;
    logic       diag_fault;
    logic       card_bad;
    logic       card_absent;
    logic       yellow_flt;
    logic       multi_flt;
    logic       dark_flt;
    logic       clash_flt;
    logic       wdt_flt;
    logic       dc_ripple;
    logic       dc_over;
    logic       dc_enh;
    logic       dc_low;
    logic       line_low;
    logic       line_ok;
  } fpa_mon_s;

  typedef struct packed {
    logic               line_power_lamp;
    logic               dc_supply_lamp;
    logic               watchdog_fault_lamp;
    logic               clash_lamp;
    logic               dark_channel_lamp;
    logic               multi_lit_lamp;
    logic               yellow_lamp;
    logic               card_missing_lamp;
    logic               self_check_lamp;
    logic               serial_traffic_lamp;
    logic [FIELD_W-1:0] field_lamp;
  } fpa_lamps_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } fpa_apb_req_s;

  typedef enum logic [1:0] {
    FPA_NORMAL = 2'b00,
    FPA_DIAG   = 2'b01,
    FPA_ADDR   = 2'b10
  } fpa_mode_e;

endpackage : fpa_pkg

// ---- fpa_annunciator.sv ----
`timescale 1ns/10ps
module fpa_annunciator #(
  parameter int unsigned MS_TICK_CYC = fpa_pkg::MS_TICK_CYC
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // APB slave
  input  wire fpa_pkg::fpa_apb_req_s apb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Operator panel
  input  wire logic               button_n,
  output fpa_pkg::fpa_lamps_s     lamps,
  output logic                    buzzer,
  // Mode indications to the firmware
  output logic                    fault_reset,
  output fpa_pkg::fpa_mode_e      mode,
  output logic                    diag_id_phase,
  output logic [3:0]              diag_screen
);

  localparam int unsigned FW = fpa_pkg::FIELD_W;

  // Square wave of a given period, on for the first half
  function automatic logic blink(input logic [12:0] t, input int unsigned per);
    return 32'(t) % per < per / 2;
  endfunction : blink

  // Blip of on_ms once per period
  function automatic logic pulse_at(input logic [12:0] t, input int unsigned per,
                                    input int unsigned on_ms);
    return 32'(t) % per < on_ms;
  endfunction : pulse_at

  fpa_pkg::fpa_mon_s  mon_q;
  logic [31:0]        cfg_live_q, cfg_act_q;
  logic [FW-1:0]      field_q, involved_q, frozen_q;
  logic [31:0]        prdata_q;
  logic               pready_q, pslverr_q;
  logic [15:0]        tick_cnt_q;
  logic               tick_q;
  logic [12:0]        ms_q;
  logic [3:0]         refresh_q;
  logic               btn_s1_q, btn_s2_q, btn_q, btn_prev_q;
  logic [4:0]         db_q;
  logic [12:0]        hold_q;
  logic [2:0]         chirp_left_q;
  logic [7:0]         chirp_ms_q;
  logic               buzz_q;
  logic               cfg_pend_q, cfg_fault_q;
  logic [7:0]         log_cnt_q;
  fpa_pkg::fpa_mode_e mode_q;
  logic [3:0]         screen_q;
  logic [11:0]        diag_ms_q;
  logic               diag_id_q;
  logic               freset_q;
  logic [5:0]         serial_q;
  logic [6:0]         shown_q;
  fpa_pkg::fpa_lamps_s lamps_q;

  logic               wr_take, rd_take, mapped, serial_ev;
  logic               btn_rise, btn_fall, hold_inc, accept, sec_tick;
  logic [12:0]        hold_next;
  logic [2:0]         chirp_req;
  logic [31:0]        rd_val;
  logic [6:0]         fault_now;

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign lamps         = lamps_q;
  assign buzzer        = buzz_q;
  assign fault_reset   = freset_q;
  assign mode          = mode_q;
  assign diag_id_phase = diag_id_q;
  assign diag_screen   = screen_q;

  // Bus decode; one wait state so read data comes from a flop
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (apb.paddr)
      fpa_pkg::OFS_MON:      rd_val = mon_q;
      fpa_pkg::OFS_CFG_LIVE: rd_val = cfg_live_q;
      fpa_pkg::OFS_CFG_ACT:  rd_val = cfg_act_q;
      fpa_pkg::OFS_FIELD:    rd_val = {14'h0000, field_q};
      fpa_pkg::OFS_INVOLVED: rd_val = {14'h0000, involved_q};
      fpa_pkg::OFS_SERIAL:   rd_val = 32'h0000_0000;
      fpa_pkg::OFS_STATUS:   rd_val = {15'h0000, log_cnt_q, screen_q, cfg_pend_q,
                                       cfg_fault_q, btn_q, mode_q};
      default:               mapped = 1'b0;
    endcase
  end

  assign wr_take   = apb.psel & apb.penable & pready_q & apb.pwrite & mapped;
  assign rd_take   = apb.psel & apb.penable & ~pready_q;
  assign serial_ev = wr_take & (apb.paddr == fpa_pkg::OFS_SERIAL);

  // APB handshake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= rd_take;
      pslverr_q <= rd_take & ~mapped;
      prdata_q  <= (rd_take & ~apb.pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // Firmware-written state words
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mon_q      <= fpa_pkg::RST_MON;
      cfg_live_q <= fpa_pkg::RST_CFG;
      field_q    <= '0;
      involved_q <= '0;
    end else if (wr_take) begin
      if (apb.paddr == fpa_pkg::OFS_MON)      mon_q      <= apb.pwdata;
      if (apb.paddr == fpa_pkg::OFS_CFG_LIVE) cfg_live_q <= apb.pwdata;
      if (apb.paddr == fpa_pkg::OFS_FIELD)    field_q    <= apb.pwdata[FW-1:0];
      if (apb.paddr == fpa_pkg::OFS_INVOLVED) involved_q <= apb.pwdata[FW-1:0];
    end
  end

  // Millisecond timebase; ms_q wraps at a common multiple of all periods
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
      ms_q       <= 13'h0000;
      refresh_q  <= 4'h0;
    end else begin
      tick_q     <= 32'(tick_cnt_q) == MS_TICK_CYC - 2;
      tick_cnt_q <= (32'(tick_cnt_q) == MS_TICK_CYC - 1) ? 16'h0000 : tick_cnt_q + 16'h0001;
      if (tick_q) begin
        ms_q      <= (32'(ms_q) == fpa_pkg::TIMEBASE_MS - 1) ? 13'h0000 : ms_q + 13'h0001;
        refresh_q <= refresh_q + 4'h1;  // Wraps every REFRESH_MS ticks
      end
    end
  end

  assign sec_tick = tick_q & (32'(ms_q) % fpa_pkg::SECOND_MS == fpa_pkg::SECOND_MS - 1);

  // Button: two-flop sync, then hold-off filter on the synced level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      btn_s1_q   <= 1'b0;
      btn_s2_q   <= 1'b0;
      btn_q      <= 1'b0;
      btn_prev_q <= 1'b0;
      db_q       <= 5'h00;
    end else begin
      btn_s1_q   <= ~button_n;
      btn_s2_q   <= btn_s1_q;
      btn_prev_q <= btn_q;
      if (btn_s2_q == btn_q) begin
        db_q <= 5'h00;
      end else if (tick_q) begin
        if (32'(db_q) == fpa_pkg::DEBOUNCE_MS - 1) begin
          btn_q <= btn_s2_q;
          db_q  <= 5'h00;
        end else begin
          db_q <= db_q + 5'h01;
        end
      end
    end
  end

  assign btn_rise  = btn_q & ~btn_prev_q;
  assign btn_fall  = ~btn_q & btn_prev_q;
  assign hold_inc  = btn_q & tick_q & (32'(hold_q) < fpa_pkg::HOLD_CFG_MS);
  assign hold_next = hold_q + 13'h0001;
  assign accept    = hold_inc & (32'(hold_next) == fpa_pkg::HOLD_CFG_MS) & cfg_pend_q;

  // Hold duration, saturating at the acceptance time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= 13'h0000;
    end else if (btn_rise) begin
      hold_q <= 13'h0000;
    end else if (hold_inc) begin
      hold_q <= hold_next;
    end
  end

  // Chirp requests at the hold milestones
  always_comb begin
    chirp_req = 3'h0;
    if (hold_inc && 32'(hold_next) == fpa_pkg::HOLD_DIAG_MS) begin
      chirp_req = fpa_pkg::CHIRPS_DIAG;
    end else if (hold_inc && 32'(hold_next) == fpa_pkg::HOLD_ADDR_MS) begin
      chirp_req = fpa_pkg::CHIRPS_ADDR;
    end else if (accept) begin
      chirp_req = fpa_pkg::CHIRPS_CFG;
    end
  end

  // Chirp train: on CHIRP_MS, off CHIRP_MS
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chirp_left_q <= 3'h0;
      chirp_ms_q   <= 8'h00;
    end else if (chirp_req != 3'h0) begin
      chirp_left_q <= chirp_req;
      chirp_ms_q   <= 8'h00;
    end else if (tick_q && chirp_left_q != 3'h0) begin
      if (32'(chirp_ms_q) == 2 * fpa_pkg::CHIRP_MS - 1) begin
        chirp_left_q <= chirp_left_q - 3'h1;
        chirp_ms_q   <= 8'h00;
      end else begin
        chirp_ms_q <= chirp_ms_q + 8'h01;
      end
    end
  end

  // Buzzer; a critical failure overrides every silencing term
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buzz_q <= 1'b0;
    end else begin
      buzz_q <= mon_q.critical
              | (chirp_left_q != 3'h0 && 32'(chirp_ms_q) < fpa_pkg::CHIRP_MS)
              | (cfg_pend_q & ~mon_q.buzz_dis
                 & pulse_at(ms_q, fpa_pkg::SECOND_MS, fpa_pkg::BEEP_MS));
    end
  end

  // Configuration watch; active settings are loaded by firmware after power-up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_act_q   <= fpa_pkg::RST_CFG;
      cfg_pend_q  <= 1'b0;
      cfg_fault_q <= 1'b0;
      log_cnt_q   <= 8'h00;
    end else begin
      if (wr_take && apb.paddr == fpa_pkg::OFS_CFG_ACT) begin
        cfg_act_q <= apb.pwdata;
      end
      if (accept) begin
        cfg_act_q   <= cfg_live_q;
        cfg_pend_q  <= 1'b0;
        cfg_fault_q <= 1'b0;
        log_cnt_q   <= log_cnt_q + 8'h01;
      end else if (sec_tick) begin
        cfg_pend_q <= cfg_live_q != cfg_act_q;
        if (cfg_live_q != cfg_act_q) begin
          cfg_fault_q <= 1'b1;  // Detection wins over a same-cycle press
        end else if (btn_fall && mode_q == fpa_pkg::FPA_NORMAL) begin
          cfg_fault_q <= 1'b0;
        end
      end else if (btn_fall && !cfg_pend_q && mode_q == fpa_pkg::FPA_NORMAL) begin
        cfg_fault_q <= 1'b0;  // Reverted settings still need a press
      end
    end
  end

  // Release decoding: short press, diagnostics, address display
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q    <= fpa_pkg::FPA_NORMAL;
      screen_q  <= 4'h0;
      diag_ms_q <= 12'h000;
      freset_q  <= 1'b0;
      diag_id_q <= 1'b1;
    end else begin
      freset_q <= 1'b0;
      diag_id_q <= 32'(diag_ms_q) < fpa_pkg::DIAG_ID_MS;  // Registered phase flag
      if (tick_q) begin
        diag_ms_q <= (32'(diag_ms_q) == fpa_pkg::DIAG_ID_MS + fpa_pkg::DIAG_DAT_MS - 1)
                     ? 12'h000 : diag_ms_q + 12'h001;
      end
      if (btn_fall) begin
        if (32'(hold_q) < fpa_pkg::HOLD_DIAG_MS) begin
          if (mode_q == fpa_pkg::FPA_DIAG) begin
            screen_q  <= (screen_q == fpa_pkg::DIAG_SCREENS - 4'h1) ? 4'h0 : screen_q + 4'h1;
            diag_ms_q <= 12'h000;  // Fault reset is not passed on here
          end else if (mode_q == fpa_pkg::FPA_NORMAL) begin
            freset_q <= 1'b1;
          end
        end else if (32'(hold_q) < fpa_pkg::HOLD_ADDR_MS) begin
          mode_q    <= (mode_q == fpa_pkg::FPA_DIAG) ? fpa_pkg::FPA_NORMAL
                                                     : fpa_pkg::FPA_DIAG;
          screen_q  <= 4'h0;
          diag_ms_q <= 12'h000;
        end else if (32'(hold_q) < fpa_pkg::HOLD_CFG_MS) begin
          mode_q <= (mode_q == fpa_pkg::FPA_ADDR) ? fpa_pkg::FPA_NORMAL
                                                  : fpa_pkg::FPA_ADDR;
        end
      end
    end
  end

  // Serial traffic stretch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_q <= 6'h00;
    end else if (serial_ev) begin
      serial_q <= 6'(fpa_pkg::PULSE_MS);
    end else if (tick_q && serial_q != 6'h00) begin
      serial_q <= serial_q - 6'h01;
    end
  end

  assign fault_now = {mon_q.diag_fault, mon_q.wdt_flt, mon_q.clash_flt, mon_q.dark_flt,
                      mon_q.multi_flt, mon_q.yellow_flt, mon_q.card_absent | mon_q.card_bad};

  // Shown faults and the field snapshot; both held while diagnostics run
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shown_q  <= 7'h00;
      frozen_q <= '0;
    end else if (mode_q == fpa_pkg::FPA_NORMAL) begin
      shown_q <= fault_now;
      if (shown_q == 7'h00) begin
        frozen_q <= field_q;  // Stops tracking once a fault is shown
      end
    end
  end

  // Lamp image, rebuilt once per refresh period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lamps_q <= '0;
    end else if (tick_q && refresh_q == 4'(fpa_pkg::REFRESH_MS - 1)) begin
      if (mon_q.line_ok & ~mon_q.line_low) begin
        lamps_q.line_power_lamp <= 1'b1;
      end else begin
        lamps_q.line_power_lamp <= 1'b0;
      end
      if (mon_q.line_low) begin
        lamps_q.line_power_lamp <= blink(ms_q, fpa_pkg::PER_2HZ);
      end
      if (mon_q.spare[0]) begin
        lamps_q.line_power_lamp <= blink(ms_q, fpa_pkg::PER_4HZ);
      end
      if (mon_q.dc_low) begin
        lamps_q.dc_supply_lamp <= 1'b1;
      end else if (mon_q.dc_enh & mon_q.dc_over) begin
        lamps_q.dc_supply_lamp <= blink(ms_q, fpa_pkg::PER_5HZ);
      end else begin
        lamps_q.dc_supply_lamp <= mon_q.dc_enh & mon_q.dc_ripple
                                  & blink(ms_q, fpa_pkg::PER_1HZ);
      end
      lamps_q.watchdog_fault_lamp <= shown_q[5] | (mon_q.wdt_sw_dis
                                     & pulse_at(ms_q, fpa_pkg::BLIP_PER_MS, fpa_pkg::PULSE_MS));
      lamps_q.clash_lamp          <= shown_q[4];
      lamps_q.dark_channel_lamp   <= shown_q[3] | ((mon_q.permit_low | mon_q.coil_low
                                     | mon_q.sf1 | mon_q.sf2)
                                     & pulse_at(ms_q, fpa_pkg::BLIP_PER_MS, fpa_pkg::PULSE_MS));
      lamps_q.multi_lit_lamp      <= shown_q[2] | (mon_q.permit_low
                                     & pulse_at(ms_q, fpa_pkg::BLIP_PER_MS, fpa_pkg::PULSE_MS));
      lamps_q.yellow_lamp         <= shown_q[1] | (mon_q.permit_low
                                     & pulse_at(ms_q, fpa_pkg::BLIP_PER_MS, fpa_pkg::PULSE_MS));
      lamps_q.card_missing_lamp   <= shown_q[0]
                                     | (cfg_pend_q & blink(ms_q, fpa_pkg::PER_1HZ));
      if (shown_q[6]) begin
        lamps_q.self_check_lamp <= 1'b1;
      end else if (mon_q.fw_rx) begin
        lamps_q.self_check_lamp <= blink(ms_q, fpa_pkg::PER_5HZ);
      end else begin
        lamps_q.self_check_lamp <= mon_q.fw_pending & blink(ms_q, fpa_pkg::PER_1HZ);
      end
      lamps_q.serial_traffic_lamp <= serial_q != 6'h00;
      if (mon_q.line_low) begin
        lamps_q.field_lamp <= '0;  // Fault lamps above keep their state
      end else if (shown_q != 7'h00) begin
        lamps_q.field_lamp <= frozen_q & ~(involved_q
                              & {FW{~blink(ms_q, fpa_pkg::PER_5HZ)}});
      end else begin
        lamps_q.field_lamp <= mon_q.card16
          ? {{2{pulse_at(ms_q, fpa_pkg::BLIP_PER_MS, fpa_pkg::PULSE_MS)}},
             field_q[FW-3:0]}
          : field_q;
      end
    end
  end

endmodule : fpa_annunciator

// ---- fpa_annunciator_sva.sv ----
`timescale 1ns/10ps
module fpa_annunciator_sva #(
  parameter int unsigned MS_TICK_CYC = 2
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rstn,
  // Bus
  input wire fpa_pkg::fpa_apb_req_s apb,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Panel and mode
  input wire logic                  button_n,
  input wire fpa_pkg::fpa_lamps_s   lamps,
  input wire logic                  buzzer,
  input wire logic                  fault_reset,
  input wire fpa_pkg::fpa_mode_e    mode,
  input wire logic                  diag_id_phase,
  input wire logic [3:0]            diag_screen
);
  localparam int unsigned REF = 16 * MS_TICK_CYC;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic        crit_q;
  logic        seen_q;
  int unsigned gap_q;
  wire logic   xfer_end = apb.psel && apb.penable && pready;
  // Critical flag mirrored from bus writes, so the buzzer can be tied to it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      crit_q <= 1'b0;
    else if (xfer_end && apb.pwrite && apb.paddr == fpa_pkg::OFS_MON)
      crit_q <= apb.pwdata[22];
  end
  // Cycles since the lamp word last moved; first move after reset has no reference
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
    end else if ($changed(lamps)) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b1;
    end else
      gap_q <= gap_q + 32'h1;
  end
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_ONE_WAIT: assert property (apb.psel && $rose(apb.penable) |=> pready)
    else $error("pready missing in second access cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED: assert property (xfer_end && apb.paddr > fpa_pkg::OFS_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside a completing transfer");
  AST_CRIT_BUZZ: assert property (crit_q && $past(crit_q, 3) |-> buzzer)
    else $error("buzzer silent during critical failure");
  AST_MODE_ON_RELEASE: assert property ($changed(mode) |-> button_n)
    else $error("mode changed while button pressed");
  AST_RESET_NORMAL_ONLY: assert property (fault_reset |-> mode == fpa_pkg::FPA_NORMAL ##1 !fault_reset)
    else $error("fault reset outside normal mode or too long");
  AST_LAMP_REFRESH: assert property ($changed(lamps) && seen_q |-> (gap_q + 32'h1) % REF == 0)
    else $error("lamps moved off the refresh period");
  COV_DIAG: cover property (mode == fpa_pkg::FPA_DIAG);
  COV_ADDR: cover property (mode == fpa_pkg::FPA_ADDR);
  COV_ERR: cover property (pslverr);
  COV_SCREEN: cover property (diag_screen == 4'h1 && diag_id_phase);
endmodule : fpa_annunciator_sva

bind fpa_annunciator fpa_annunciator_sva #(.MS_TICK_CYC(MS_TICK_CYC)) fpa_annunciator_sva_i (
  .clk(clk), .rstn(rstn), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .button_n(button_n), .lamps(lamps), .buzzer(buzzer), .fault_reset(fault_reset),
  .mode(mode), .diag_id_phase(diag_id_phase), .diag_screen(diag_screen));

// ---- fpa_operator.sv ----
`timescale 1ns/10ps
module fpa_operator #(
  parameter int MS = 2
) (
  // Panel
  input  wire logic clk,
  input  wire logic buzzer,
  output logic      button_n
);
  int   chirps = 0;
  logic buz_q = 1'b0;
  initial button_n = 1'b1;
  // Each rising buzzer edge is one chirp heard
  always @(posedge clk) begin
    if (buzzer === 1'b1 && buz_q !== 1'b1) chirps++;
    buz_q <= buzzer;
  end
  // Press with contact bounce, hold, release, then listen a while
  task automatic hold(input int ms);
    chirps = 0;
    repeat (3) begin
      @(posedge clk) button_n <= 1'b0;
      @(posedge clk) button_n <= 1'b1;
    end
    @(posedge clk) button_n <= 1'b0;
    repeat (ms * MS) @(posedge clk);
    button_n <= 1'b1;
    repeat (1100 * MS) @(posedge clk);
  endtask : hold
endmodule : fpa_operator

// ---- test_front_panel_annunciator.sv ----
`timescale 1ns/10ps
module test_front_panel_annunciator;
  localparam int MS = 2;
  typedef struct { logic [31:0] mon; int idx; int ed; } fpa_row_s;
  logic                  clk = 1'b0;
  logic                  rstn = 1'b0;
  fpa_pkg::fpa_apb_req_s apb = '0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  button_n;
  fpa_pkg::fpa_lamps_s   lamps;
  logic                  buzzer;
  logic                  fault_reset;
  fpa_pkg::fpa_mode_e    mode;
  logic                  diag_id_phase;
  logic [3:0]            diag_screen;
  wire logic [29:0]      obs = {diag_id_phase, buzzer, lamps};
  int                    n_errors = 0;
  int                    check_count = 0;
  int                    n_freset = 0;
  logic [31:0]           q;
  logic                  e;
  int                    ed;
  int                    on;
  // Monitor word, observed bit, expected level changes per second (0 = steady on)
  fpa_row_s rows [10] = '{'{32'h1, 27, 0}, '{32'h2, 27, 4}, '{32'h0100_0001, 27, 8},
    '{32'h5, 26, 0}, '{32'h19, 26, 10}, '{32'h29, 26, 2}, '{32'h4001, 19, 10},
    '{32'h8001, 19, 2}, '{32'h41, 25, 0}, '{32'h81, 24, 0}};
  always #12.5 clk = ~clk;
  // Fault-reset pulses handed to the firmware side
  always @(posedge clk)
    if (fault_reset === 1'b1) n_freset++;
  fpa_annunciator #(.MS_TICK_CYC(MS)) fpa_annunciator_i (.clk(clk), .rstn(rstn), .apb(apb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .button_n(button_n), .lamps(lamps),
    .buzzer(buzzer), .fault_reset(fault_reset), .mode(mode), .diag_id_phase(diag_id_phase),
    .diag_screen(diag_screen));
  fpa_operator #(.MS(MS)) fpa_operator_i (.clk(clk), .buzzer(buzzer), .button_n(button_n));
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s: got %h want %h", $time, s, got, exp);
    end
  endtask : chk_val
  task automatic chk_rng(input int got, input int lo, input int hi, input string s);
    check_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("ERROR %0t %s: got %0d want %0d..%0d", $time, s, got, lo, hi);
    end
  endtask : chk_rng
  // One bus transfer; the request stands until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    apb <= '0;
    @(posedge clk);
  endtask : xfer
  // Level changes and on-time in ms of one observed output over a window
  task automatic watch(input int i, input int ms);
    logic p;
    p = obs[i];
    ed = 0;
    on = 0;
    repeat (ms * MS) begin
      @(posedge clk);
      if (obs[i] !== p) ed++;
      p = obs[i];
      if (obs[i] === 1'b1) on++;
    end
    on = on / MS;
  endtask : watch
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // Hang guard
  initial begin
    repeat (98000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  // Main sequence: reset and bus refusal first, then table, pulses and button work
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_val({lamps, buzzer, mode, diag_id_phase}, 32'h1, "reset outputs");
    xfer(1'b0, 8'h1c, 32'h0);
    chk_val({e, q[30:0]}, 32'h8000_0000, "unmapped read");
    $display("test reset and bus done");
    foreach (rows[k]) begin
      xfer(1'b1, fpa_pkg::OFS_MON, rows[k].mon);
      watch(rows[k].idx, 40);
      watch(rows[k].idx, 1000);
      chk_rng(ed, rows[k].ed - (rows[k].ed > 0), rows[k].ed + (rows[k].ed > 0), "edges");
      if (rows[k].ed == 0) chk_rng(on, 1000, 1000, "steady lamp");
    end
    xfer(1'b1, fpa_pkg::OFS_MON, 32'h2f01);
    watch(27, 40);
    chk_val({22'h0, lamps[27:18]}, 32'h23e, "fault lamps");
    xfer(1'b1, fpa_pkg::OFS_MON, 32'h7_0001);
    watch(25, 2000);
    chk_rng(on, 32, 80, "disabled blip ms");
    $display("test lamp table done");
    xfer(1'b1, fpa_pkg::OFS_SERIAL, 32'h0);
    watch(18, 150);
    chk_rng(on, 32, 66, "serial lamp ms");
    xfer(1'b1, fpa_pkg::OFS_MON, 32'h0040_0001);
    watch(28, 300);
    chk_rng(on, 299, 300, "critical buzzer ms");
    xfer(1'b1, fpa_pkg::OFS_MON, 32'h1);
    $display("test serial and critical done");
    fpa_operator_i.hold(2000);
    chk_val({fpa_operator_i.chirps[3:0], mode}, {4'h1, fpa_pkg::FPA_DIAG}, "diag entry");
    fpa_operator_i.hold(200);
    chk_val({27'h0, diag_screen, diag_id_phase}, 32'h2, "next screen");
    fpa_operator_i.hold(2000);
    chk_val({30'h0, mode}, {30'h0, fpa_pkg::FPA_NORMAL}, "diag exit");
    fpa_operator_i.hold(3500);
    chk_val({fpa_operator_i.chirps[3:0], mode}, {4'h3, fpa_pkg::FPA_ADDR}, "addr entry");
    fpa_operator_i.hold(3500);
    chk_val({30'h0, mode}, {30'h0, fpa_pkg::FPA_NORMAL}, "addr exit");
    $display("test button modes done");
    xfer(1'b1, fpa_pkg::OFS_CFG_LIVE, 32'h5);
    watch(28, 1100);
    watch(28, 2000);
    chk_rng(ed, 3, 5, "pending beeps");
    watch(20, 1000);
    chk_rng(ed, 1, 3, "pending card blink");
    xfer(1'b1, fpa_pkg::OFS_MON, 32'h0080_0001);
    fpa_operator_i.hold(5500);
    chk_val(fpa_operator_i.chirps, 32'h8, "accept chirps");
    xfer(1'b0, fpa_pkg::OFS_CFG_ACT, 32'h0);
    chk_val(q, 32'h5, "config adopted");
    xfer(1'b0, fpa_pkg::OFS_STATUS, 32'h0);
    chk_val(q & 32'h0001_fe10, 32'h0000_0200, "pending cleared, log entry");
    $display("test config accept done");
    xfer(1'b1, fpa_pkg::OFS_CFG_LIVE, 32'h6);
    watch(28, 1100);
    xfer(1'b1, fpa_pkg::OFS_CFG_LIVE, 32'h5);
    watch(28, 1100);
    xfer(1'b0, fpa_pkg::OFS_STATUS, 32'h0);
    chk_val(q & 32'h18, 32'h8, "reverted, fault held");
    fpa_operator_i.hold(200);
    xfer(1'b0, fpa_pkg::OFS_STATUS, 32'h0);
    chk_val({q[4:3], n_freset[29:0]}, 32'h1, "press clears fault");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_val({lamps, buzzer, mode, diag_id_phase}, 32'h1, "outputs after reset");
    xfer(1'b0, fpa_pkg::OFS_CFG_ACT, 32'h0);
    chk_val(q, fpa_pkg::RST_CFG, "active config after reset");
    $display("test revert and reset done");
    end_sim();
  end
endmodule : test_front_panel_annunciator
